// ===== testbench/core_fetch_model.sv
// Core fetch model feeding the trap logic
`timescale 1ns/1ps
`default_nettype none
module core_fetch_model (
   input wire logic req_in,
   input wire logic [7:0] word_in,
   input wire logic mapped_in,
   input wire logic [14:0] pc_in,
   output logic [7:0] fetch_word_out,
   output logic fetch_valid_out,
   output logic fetch_mapped_out,
   output logic [14:0] fetch_pc_out
);
   // Missing memory drives the inverted PC low byte, zero only when that byte is FF
   assign fetch_word_out = mapped_in ? word_in : ~pc_in[7:0];
   assign fetch_valid_out = req_in;
   assign fetch_mapped_out = mapped_in;
   assign fetch_pc_out = pc_in;
endmodule : core_fetch_model
`default_nettype wire

// ===== testbench/tb_trap_wake_irq.sv
// Self-checking bench for the trap and wake-up interrupt logic
`timescale 1ns/1ps
`default_nettype none
module tb_trap_wake_irq;
   import trap_wake_pkg::*;
   logic clk = 1'b0, arst_n = 1'b0, req = 1'b0, mapped = 1'b1, pop = 1'b0;
   logic clr = 1'b0, vsel = 1'b0, global_irq_enable = 1'b0, gate = 1'b0;
   logic rfi = 1'b0, lp = 1'b0, irq, wk, wk_isr, srv;
   logic [14:0] p;
   int k;
   int n;
   logic [7:0] word = 8'h00, wen = 8'h00, wedg = 8'h00, wclr = 8'h00;
   logic [7:0] pins = 8'h00, f_word, instr, wpend, w;
   logic [8:0] sp = 9'h06f;
   logic [14:0] pc = 15'h0000, fpc = 15'h0000, f_pc, ret, pop_pc, vpc;
   logic f_valid, f_mapped, flag, ack, ovr, vload, m;
   int n_errors = 0;
   int total_checks = 0;
   int i;
   int j;
   always #4 clk = ~clk;
   core_fetch_model core_fetch_model_inst (.req_in(req), .word_in(word),
      .mapped_in(mapped), .pc_in(fpc), .fetch_word_out(f_word),
      .fetch_valid_out(f_valid), .fetch_mapped_out(f_mapped),
      .fetch_pc_out(f_pc));
   trap_wake_irq trap_wake_irq_inst (.CLK_IN(clk), .ARST_N_IN(arst_n),
      .FETCH_WORD_IN(f_word), .FETCH_VALID_IN(f_valid),
      .FETCH_MAPPED_IN(f_mapped), .FETCH_PC_IN(f_pc), .NEXT_PC_IN(pc),
      .POP_IN(pop), .SP_IN(sp), .CLEAR_PENDING_INSTR_IN(clr),
      .VECTOR_SELECT_INSTR_IN(vsel), .PC_IN(pc),
      .RETURN_FROM_IRQ_INSTR_IN(rfi), .GLOBAL_IRQ_ENABLE_IN(global_irq_enable),
      .WAKE_PORT_IRQ_GATE_IN(gate), .WAKE_ENABLE_REG_IN(wen),
      .WAKE_EDGE_REG_IN(wedg), .WAKE_PEND_CLR_IN(wclr), .WAKE_PIN_IN(pins),
      .LOW_POWER_IN(lp), .INSTR_WORD_OUT(instr),
      .TRAP_PENDING_FLAG_OUT(flag), .TRAP_ACK_OUT(ack),
      .RETURN_ADDR_OUT(ret), .POP_OVERRUN_OUT(ovr), .POP_PC_OUT(pop_pc),
      .IRQ_REQ_OUT(irq), .VEC_LOAD_OUT(vload), .VEC_PC_OUT(vpc),
      .WAKE_PENDING_REG_OUT(wpend), .WAKE_OUT(wk), .WAKE_TO_ISR_OUT(wk_isr),
      .IN_SERVICE_OUT(srv));
   // =====================================================
   // Expectations and checks
   function automatic logic trap_exp(input logic [7:0] wd, input logic mp);
      return (wd == TRAP_OPCODE) || !mp;
   endfunction : trap_exp
   function automatic logic [14:0] vexp(input logic [14:0] p,
      input logic [7:0] low);
      return {p[14:8], low};
   endfunction : vexp
   task automatic check(input logic [14:0] seen, input logic [14:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic summarize();
      $display("checks=%0d errors=%0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : summarize
   // =====================================================
   // Bus cycle tasks
   task automatic fetch(input logic [7:0] wd, input logic mp, input logic c);
      @(posedge clk);
      req <= 1'b1;
      word <= wd;
      mapped <= mp;
      clr <= c;
      fpc <= 15'($urandom);
      #1;
      check(irq, trap_exp(wd, mp));
      @(posedge clk);
      req <= 1'b0;
      clr <= 1'b0;
      #1;
   endtask : fetch
   task automatic vec(input logic [7:0] low);
      @(posedge clk);
      vsel <= 1'b1;
      pc <= 15'($urandom);
      @(posedge clk);
      vsel <= 1'b0;
      #1;
      check(vload, 1'b1);
      check(vpc, vexp(pc, low));
   endtask : vec
   // =====================================================
   // Tests
   initial begin
      #100000;
      n_errors++;
      summarize();
   end
   initial begin
      void'($urandom(44));
      repeat (10) @(posedge clk);
      arst_n <= 1'b1;
      #1;
      check(flag, TRAP_RESET_VAL);
      check(wpend, WAKE_RESET_VAL);
      fetch(TRAP_OPCODE, 1'b1, 1'b0);
      check(flag, 1'b1);
      check(ack, 1'b1);
      check(ret, fpc);
      @(posedge clk);
      #1;
      check(ack, 1'b0);
      vec(VEC_TRAP);
      fetch(TRAP_OPCODE, 1'b1, 1'b1);
      check(flag, 1'b1);
      for (i = 0; i < 16; i++) begin
         w = (i == 0) ? 8'h00 : 8'($urandom);
         m = (i == 1) ? 1'b0 : 1'($urandom);
         fetch(8'h01, 1'b1, 1'b1);
         check(flag, 1'b0);
         fetch(w, m, 1'b0);
         check(flag, trap_exp(w, m));
         check(instr, m ? w : BLANK_WORD);
      end
      @(posedge clk);
      pop <= 1'b1;
      sp <= STACK_LIMIT + 9'h001;
      #1;
      check(ovr, 1'b1);
      check(pop_pc, POP_LIMIT_PC);
      @(posedge clk);
      sp <= STACK_LIMIT;
      #1;
      check(ovr, 1'b0);
      pop <= 1'b0;
      fetch(8'h01, 1'b1, 1'b1);
      global_irq_enable <= 1'b1;
      gate <= 1'b1;
      for (j = 0; j < 4; j++) begin
         i = $urandom_range(7, 0);
         wen <= 8'h00;
         rfi <= 1'b1;
         wedg <= 8'($urandom);
         pins <= wedg;
         repeat (6) @(posedge clk);
         pins <= wedg;
         rfi <= 1'b0;
         wclr <= 8'hff;
         repeat (6) @(posedge clk);
         wclr <= 8'h00;
         @(posedge clk);
         pins[i] <= ~pins[i];
         repeat (6) @(posedge clk);
         #1;
         check(wpend, 8'h01 << i);
         check(srv, 1'b0);
         vec(VEC_DEFAULT);
         wen <= 8'h01 << i;
         p = pc;
         vec(VEC_WAKE);
         check(srv, 1'b1);
         check(irq, 1'b0);
         check(ret, p);
         fetch(TRAP_OPCODE, 1'b1, 1'b0);
         vec(VEC_TRAP);
         fetch(8'h01, 1'b1, 1'b1);
      end
      @(posedge clk);
      lp <= 1'b1;
      wen <= 8'hff;
      wedg <= 8'h00;
      for (j = 0; j < 2; j++) begin
         gate <= j[0];
         pins <= 8'h00;
         repeat (4) @(posedge clk);
         pins[0] <= 1'b1;
         k = 0;
         n = 0;
         repeat (8) begin
            @(posedge clk);
            #1;
            k += wk;
            n += wk_isr;
         end
         check(15'(k), 15'h0001);
         check(15'(n), 15'(j));
         @(posedge clk);
      end
      summarize();
   end
endmodule : tb_trap_wake_irq
`default_nettype wire

// ===== verilog/trap_wake_irq.sv
// Software trap and wake-up port interrupt arbitration
// How it works
// RL1: Reset clears the trap pending flag
// RL2: Trap event sets the pending flag
// RL3: Clear-pending instruction clears the flag unless a trap event comes in the same cycle
// RL4: Trap flag has no software address
// RL5: Fetched opcode 00 raises trap
// RL6: Missing program memory reads as zeroes
// RL7: Stack over-pop loads program counter 7FFF
// RL8: Trap has top arbitration priority
// RL9: Trap keeps global enable, blocks others
// RL10: Only a trap interrupts trap service
// RL11: Trap pushes its own instruction address
// RL12: Trap acknowledged at once
// RL13: Eight edge wake inputs, one vector
// RL14: Per-pin wake enable bit
// RL15: Per-pin rising or falling edge select
// RL16: Pending register latches each pin edge
// RL17: Wake request needs port and global enable
// RL18: Disabled wake resumes after halt instruction
// RL19: Enabled wake runs service routine first
// RL20: Maskable never preempts running service
// RL21: Trap preempts maskable service
// RL22: Vector select replaces PC low byte
// RL23: No active interrupt gives default vector
// RL24: Wake pins synchronised before edge detection
`timescale 1ns/1ps
`default_nettype none
module trap_wake_irq
   import trap_wake_pkg::*;
#(
   parameter int PINS = trap_wake_pkg::WAKE_PINS
) (
   input wire logic CLK_IN,
   input wire logic ARST_N_IN,
   input wire logic [7:0] FETCH_WORD_IN,
   input wire logic FETCH_VALID_IN,
   input wire logic FETCH_MAPPED_IN,
   input wire logic [14:0] FETCH_PC_IN,
   input wire logic [14:0] NEXT_PC_IN,
   input wire logic POP_IN,
   input wire logic [8:0] SP_IN,
   input wire logic CLEAR_PENDING_INSTR_IN,
   input wire logic VECTOR_SELECT_INSTR_IN,
   input wire logic [14:0] PC_IN,
   input wire logic RETURN_FROM_IRQ_INSTR_IN,
   input wire logic GLOBAL_IRQ_ENABLE_IN,
   input wire logic WAKE_PORT_IRQ_GATE_IN,
   input wire logic [PINS-1:0] WAKE_ENABLE_REG_IN,
   input wire logic [PINS-1:0] WAKE_EDGE_REG_IN,
   input wire logic [PINS-1:0] WAKE_PEND_CLR_IN,
   input wire logic [PINS-1:0] WAKE_PIN_IN,
   input wire logic LOW_POWER_IN,
   output logic [7:0] INSTR_WORD_OUT,
   output logic TRAP_PENDING_FLAG_OUT,
   output logic TRAP_ACK_OUT,
   output logic [14:0] RETURN_ADDR_OUT,
   output logic POP_OVERRUN_OUT,
   output logic [14:0] POP_PC_OUT,
   output logic IRQ_REQ_OUT,
   output logic VEC_LOAD_OUT,
   output logic [14:0] VEC_PC_OUT,
   output logic [PINS-1:0] WAKE_PENDING_REG_OUT,
   output logic WAKE_OUT,
   output logic WAKE_TO_ISR_OUT,
   output logic IN_SERVICE_OUT
);
   import trap_wake_pkg::*;

   logic [7:0] fetched;
   logic trap_event;
   logic [PINS-1:0] edges;
   logic wake_active;
   logic wake_req;
   logic trap_pending_flag_reg;
   logic [PINS-1:0] wake_pending_reg;
   logic [7:0] instr_word_reg;
   logic trap_ack_reg;
   logic [14:0] return_addr_reg;
   logic [7:0] vec_low;
   logic vec_load_reg;
   logic [14:0] vec_pc_reg;
   logic in_service_reg;
   logic wake_reg;
   logic wake_isr_reg;

   // ==================================================
   // Trap detection on fetch
   assign fetched = FETCH_MAPPED_IN ? FETCH_WORD_IN : BLANK_WORD; // RL6
   assign trap_event = FETCH_VALID_IN && (fetched == TRAP_OPCODE); // RL5

   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         instr_word_reg <= 8'h00;
      end else if (FETCH_VALID_IN) begin
         instr_word_reg <= fetched;
      end
   end

   // Over-pop check against the stack limit
   assign POP_OVERRUN_OUT = POP_IN && (SP_IN > STACK_LIMIT); // RL7
   assign POP_PC_OUT = POP_LIMIT_PC; // RL7

   // ==================================================
   // Trap pending flag: internal only, no address
   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         trap_pending_flag_reg <= TRAP_RESET_VAL; // RL1
      end else if (trap_event) begin
         trap_pending_flag_reg <= 1'b1; // RL2
      end else if (CLEAR_PENDING_INSTR_IN) begin
         trap_pending_flag_reg <= 1'b0; // RL3
      end
   end
   // RL4: visible only as a status output, never writable

   // Trap acknowledge and return address
   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         trap_ack_reg <= 1'b0;
         return_addr_reg <= 15'h0000;
      end else begin
         trap_ack_reg <= trap_event; // RL12
         if (trap_event) begin
            return_addr_reg <= FETCH_PC_IN; // RL11
         end else if (wake_req && !in_service_reg) begin
            return_addr_reg <= NEXT_PC_IN;
         end
      end
   end

   // ==================================================
   // Wake-up port edges and pending bits
   wake_edge_detect #(
      .PINS(PINS)
   ) u_edges (
      .clk_in(CLK_IN),
      .arst_n_in(ARST_N_IN),
      .pin_in(WAKE_PIN_IN),
      .falling_sel_in(WAKE_EDGE_REG_IN),
      .edge_out(edges)
   );

   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         wake_pending_reg <= WAKE_RESET_VAL;
      end else begin
         // Set wins over clear
         wake_pending_reg <= (wake_pending_reg & ~WAKE_PEND_CLR_IN)
            | edges; // RL16
      end
   end

   assign wake_active = |(wake_pending_reg & WAKE_ENABLE_REG_IN); // RL14 RL13
   assign wake_req = wake_active && WAKE_PORT_IRQ_GATE_IN
      && GLOBAL_IRQ_ENABLE_IN && !trap_pending_flag_reg; // RL17 RL9

   // ==================================================
   // Service tracking
   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         in_service_reg <= 1'b0;
      end else if (wake_req && !in_service_reg) begin
         in_service_reg <= 1'b1;
      end else if (RETURN_FROM_IRQ_INSTR_IN) begin
         in_service_reg <= 1'b0;
      end
   end

   // Maskable waits; trap goes straight through
   assign IRQ_REQ_OUT = trap_event
      || (wake_req && !in_service_reg); // RL20 RL21 RL10 RL12

   // ==================================================
   // Wake from halt or idle
   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         wake_reg <= 1'b0;
         wake_isr_reg <= 1'b0;
      end else begin
         wake_reg <= LOW_POWER_IN && |(edges & WAKE_ENABLE_REG_IN);
         wake_isr_reg <= LOW_POWER_IN && |(edges & WAKE_ENABLE_REG_IN)
            && WAKE_PORT_IRQ_GATE_IN && GLOBAL_IRQ_ENABLE_IN; // RL19 RL18
      end
   end

   // ==================================================
   // Vector selection
   always_comb begin
      if (trap_pending_flag_reg) begin
         vec_low = VEC_TRAP; // RL8 RL9
      end else if (wake_active && WAKE_PORT_IRQ_GATE_IN) begin
         vec_low = VEC_WAKE; // RL13
      end else begin
         vec_low = VEC_DEFAULT; // RL23
      end
   end

   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         vec_load_reg <= 1'b0;
         vec_pc_reg <= 15'h0000;
      end else begin
         vec_load_reg <= VECTOR_SELECT_INSTR_IN;
         if (VECTOR_SELECT_INSTR_IN) begin
            vec_pc_reg <= {PC_IN[14:8], vec_low}; // RL22
         end
      end
   end

   // ==================================================
   // Outputs
   assign INSTR_WORD_OUT = instr_word_reg;
   assign TRAP_PENDING_FLAG_OUT = trap_pending_flag_reg;
   assign TRAP_ACK_OUT = trap_ack_reg;
   assign RETURN_ADDR_OUT = return_addr_reg;
   assign VEC_LOAD_OUT = vec_load_reg;
   assign VEC_PC_OUT = vec_pc_reg;
   assign WAKE_PENDING_REG_OUT = wake_pending_reg;
   assign WAKE_OUT = wake_reg;
   assign WAKE_TO_ISR_OUT = wake_isr_reg;
   assign IN_SERVICE_OUT = in_service_reg;

   // ==================================================
   // Checks
   a_trap_sets_flag: assert property (@(posedge CLK_IN) // RL2
      disable iff (!ARST_N_IN) trap_event |=> trap_pending_flag_reg)
      else $error("Trap did not set pending flag");
   a_clear_flag: assert property (@(posedge CLK_IN) // RL3
      disable iff (!ARST_N_IN)
      CLEAR_PENDING_INSTR_IN && !trap_event |=> !trap_pending_flag_reg)
      else $error("Clear instruction left flag set");
   a_trap_ack_now: assert property (@(posedge CLK_IN) // RL12
      disable iff (!ARST_N_IN) trap_event |=> TRAP_ACK_OUT)
      else $error("Trap not acknowledged next cycle");
   a_trap_ret_addr: assert property (@(posedge CLK_IN) // RL11
      disable iff (!ARST_N_IN)
      trap_event |=> RETURN_ADDR_OUT == $past(FETCH_PC_IN))
      else $error("Trap return address wrong");
   a_trap_vector: assert property (@(posedge CLK_IN) // RL8
      disable iff (!ARST_N_IN)
      VECTOR_SELECT_INSTR_IN && trap_pending_flag_reg
      |=> VEC_PC_OUT[7:0] == VEC_TRAP)
      else $error("Trap vector not chosen");
   a_high_byte: assert property (@(posedge CLK_IN) // RL22
      disable iff (!ARST_N_IN)
      VECTOR_SELECT_INSTR_IN |=> VEC_PC_OUT[14:8] == $past(PC_IN[14:8]))
      else $error("Vector changed high byte");
   a_default_vec: assert property (@(posedge CLK_IN) // RL23
      disable iff (!ARST_N_IN)
      VECTOR_SELECT_INSTR_IN && !trap_pending_flag_reg && !wake_active
      |=> VEC_PC_OUT[7:0] == VEC_DEFAULT)
      else $error("Default vector not used");
   a_trap_blocks: assert property (@(posedge CLK_IN) // RL9
      disable iff (!ARST_N_IN) trap_pending_flag_reg |-> !wake_req)
      else $error("Wake request during trap");
   a_wake_gate: assert property (@(posedge CLK_IN) // RL17
      disable iff (!ARST_N_IN)
      !(WAKE_PORT_IRQ_GATE_IN && GLOBAL_IRQ_ENABLE_IN) |-> !wake_req)
      else $error("Wake request without enable");
   a_no_preempt: assert property (@(posedge CLK_IN) // RL20
      disable iff (!ARST_N_IN)
      in_service_reg && !trap_event |-> !IRQ_REQ_OUT)
      else $error("Maskable preempted service");
   a_pend_latch: assert property (@(posedge CLK_IN) // RL16
      disable iff (!ARST_N_IN) |edges |=> |WAKE_PENDING_REG_OUT)
      else $error("Wake edge not latched");

   // ==================================================
   // Further checks
   a_flag_holds: assert property (@(posedge CLK_IN) // RL9
      disable iff (!ARST_N_IN)
      trap_pending_flag_reg && !CLEAR_PENDING_INSTR_IN
      |=> trap_pending_flag_reg)
      else $error("Trap flag dropped without clear");
   a_flag_no_set: assert property (@(posedge CLK_IN) // RL4
      disable iff (!ARST_N_IN)
      !trap_pending_flag_reg && !trap_event
      |=> !trap_pending_flag_reg)
      else $error("Trap flag set without trap");
   a_irq_on_trap: assert property (@(posedge CLK_IN) // RL21
      disable iff (!ARST_N_IN)
      trap_event
      |-> IRQ_REQ_OUT)
      else $error("Trap did not raise request");
   a_blank_fetch: assert property (@(posedge CLK_IN) // RL6
      disable iff (!ARST_N_IN)
      FETCH_VALID_IN && !FETCH_MAPPED_IN
      |=> INSTR_WORD_OUT == BLANK_WORD)
      else $error("Missing memory not read as zero");
   a_trap_opcode: assert property (@(posedge CLK_IN) // RL5
      disable iff (!ARST_N_IN)
      FETCH_VALID_IN && FETCH_MAPPED_IN && FETCH_WORD_IN == TRAP_OPCODE
      |=> TRAP_ACK_OUT && TRAP_PENDING_FLAG_OUT)
      else $error("Trap opcode not trapped");
   a_over_pop: assert property (@(posedge CLK_IN) // RL7
      disable iff (!ARST_N_IN)
      POP_IN && (SP_IN > STACK_LIMIT)
      |-> POP_OVERRUN_OUT && POP_PC_OUT == POP_LIMIT_PC)
      else $error("Over-pop not flagged");
   a_wake_vector: assert property (@(posedge CLK_IN) // RL13
      disable iff (!ARST_N_IN)
      VECTOR_SELECT_INSTR_IN && !trap_pending_flag_reg && wake_active
      && WAKE_PORT_IRQ_GATE_IN |=> VEC_PC_OUT[7:0] == VEC_WAKE)
      else $error("Wake vector not chosen");
   a_vec_even: assert property (@(posedge CLK_IN) // RL22
      disable iff (!ARST_N_IN)
      VEC_LOAD_OUT
      |-> !VEC_PC_OUT[0])
      else $error("Vector low byte odd");
   a_wake_enable: assert property (@(posedge CLK_IN) // RL14
      disable iff (!ARST_N_IN)
      !(|(wake_pending_reg & WAKE_ENABLE_REG_IN))
      |-> !wake_req)
      else $error("Wake request from disabled pin");
   a_wake_resume: assert property (@(posedge CLK_IN) // RL18
      disable iff (!ARST_N_IN)
      LOW_POWER_IN && |(edges & WAKE_ENABLE_REG_IN) && !WAKE_PORT_IRQ_GATE_IN
      |=> WAKE_OUT && !WAKE_TO_ISR_OUT)
      else $error("Disabled wake went to service");
   a_wake_isr: assert property (@(posedge CLK_IN) // RL19
      disable iff (!ARST_N_IN)
      LOW_POWER_IN && |(edges & WAKE_ENABLE_REG_IN) && WAKE_PORT_IRQ_GATE_IN
      && GLOBAL_IRQ_ENABLE_IN |=> WAKE_OUT && WAKE_TO_ISR_OUT)
      else $error("Enabled wake skipped service");
   a_service_hold: assert property (@(posedge CLK_IN) // RL20
      disable iff (!ARST_N_IN)
      in_service_reg && !RETURN_FROM_IRQ_INSTR_IN
      |=> in_service_reg)
      else $error("Service ended without return");
   a_pend_hold: assert property (@(posedge CLK_IN) // RL16
      disable iff (!ARST_N_IN)
      1'b1 |=> (($past(wake_pending_reg) & ~$past(WAKE_PEND_CLR_IN))
      & ~wake_pending_reg) == '0)
      else $error("Pending bit lost without clear");
   a_edge_once: assert property (@(posedge CLK_IN) // RL24
      disable iff (!ARST_N_IN)
      |edges
      |=> (edges & $past(edges)) == '0)
      else $error("Wake edge seen twice");
endmodule : trap_wake_irq
`default_nettype wire

// ===== verilog/trap_wake_pkg.sv
// Constants for the trap and wake-up interrupt logic
package trap_wake_pkg;
   localparam int WAKE_PINS = 8;
   localparam logic [7:0] TRAP_OPCODE = 8'h00;
   localparam logic [7:0] BLANK_WORD = 8'h00;
   localparam logic [14:0] POP_LIMIT_PC = 15'h7fff;
   localparam logic [8:0] STACK_LIMIT = 9'h06f;
   localparam logic [7:0] VEC_TRAP = 8'hfe;
   localparam logic [7:0] VEC_WAKE = 8'he2;
   localparam logic [7:0] VEC_DEFAULT = 8'he0;
   localparam logic TRAP_RESET_VAL = 1'b0;
   localparam logic [7:0] WAKE_RESET_VAL = 8'h00;
endpackage : trap_wake_pkg

// ===== verilog/wake_edge_detect.sv
// Synchronised per-pin wake-up edge detector
`timescale 1ns/1ps
`default_nettype none
module wake_edge_detect #(
   parameter int PINS = 8
) (
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic [PINS-1:0] pin_in,
   input wire logic [PINS-1:0] falling_sel_in,
   output logic [PINS-1:0] edge_out
);
   logic [PINS-1:0] sync1_reg;
   logic [PINS-1:0] sync2_reg;
   logic [PINS-1:0] last_reg;
   // ==================================================
   // Synchroniser and history
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
         last_reg <= '0;
      end else begin
         sync1_reg <= pin_in;
         sync2_reg <= sync1_reg; // RL24
         last_reg <= sync2_reg;
      end
   end
   // ==================================================
   // Edge select per pin
   genvar i;
   for (i = 0; i < PINS; i++) begin : g_pin
      assign edge_out[i] = falling_sel_in[i] ?
         (last_reg[i] & ~sync2_reg[i]) :
         (~last_reg[i] & sync2_reg[i]); // RL15
   end
endmodule : wake_edge_detect
`default_nettype wire
